// ==== logic/sfwp_device.sv ====
// Flash end: frame decoder, block protection, OTP locks and busy timing
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfwp_device #(
	parameter int unsigned PROG_CYC  = 64,
	parameter int unsigned ERASE_CYC = 512,
	parameter int unsigned SRW_CYC   = 32
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	sfwp_if.device           link,
	input  wire logic        quad_mode_in,
	input  wire logic        factory_lock_in,
	output logic             write_in_progress_out,
	output logic             write_enable_latch_out,
	output logic             dpd_out,
	output logic             otp_mode_out,
	output logic             er_pulse_out,
	output logic [1:0]       er_kind_out,
	output logic [23:0]      er_addr_out,
	output logic             pg_we_out,
	output logic             pg_otp_out,
	output logic [23:0]      pg_addr_out,
	output logic [7:0]       pg_data_out
);
	// ----------------------------------------
	// Pin synchronisers and edges
	// ----------------------------------------
	logic [3:0] s1_q, s2_q;
	logic       sclk_p_q, cs_p_q;
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			s1_q     <= 4'hd;
			s2_q     <= 4'hd;
			sclk_p_q <= 1'b0;
			cs_p_q   <= 1'b1;
		end else begin
			s1_q     <= {link.cs_n, link.sclk, link.si, link.wp_n};
			s2_q     <= s1_q;
			sclk_p_q <= s2_q[2];
			cs_p_q   <= s2_q[3];
		end
	end
	wire cs_n_s   = s2_q[3];
	wire sclk_s   = s2_q[2];
	wire si_s     = s2_q[1];
	wire wp_n_s   = s2_q[0];
	wire sck_rise = sclk_s & ~sclk_p_q & ~cs_n_s;
	wire sck_fall = ~sclk_s & sclk_p_q & ~cs_n_s;
	wire cs_fall  = ~cs_n_s & cs_p_q;
	wire cs_rise  = cs_n_s & ~cs_p_q;

	// ----------------------------------------
	// Frame shifter
	// ----------------------------------------
	sfwp_pkg::sfwp_dev_st_t st_q;
	logic [2:0]  bit_q;
	logic [9:0]  nb_q;
	logic [7:0]  sh_q, op_q, srw_q, out_q;
	logic [23:0] addr_q, pbase_q;
	logic [8:0]  pg_n_q, str_q;
	logic [7:0]  sidx_q;
	logic [7:0]  page_mem [0:255];
	logic        so_q, so_oe_q;

	logic       wel_q, tbs_q, swl_q, otp_q, dpd_q, cust_q, fac_q, strap_q, wip_q;
	logic [3:0] lvl_q;
	logic [15:0] wcnt_q;

	wire [7:0] byte_w    = {sh_q[6:0], si_s};
	wire       byte_done = (st_q == sfwp_pkg::DS_ACTIVE) & sck_rise & (bit_q == 3'h7);
	wire [7:0] cur_op    = (nb_q == 10'h0) ? byte_w : op_q;
	wire       cur_rd    = (cur_op == sfwp_pkg::OP_RD_STATUS) | (cur_op == sfwp_pkg::OP_RD_SECURITY);
	wire       rd_q      = (op_q == sfwp_pkg::OP_RD_STATUS) | (op_q == sfwp_pkg::OP_RD_SECURITY);
	wire       known_w   = cur_rd | (byte_w == sfwp_pkg::OP_WR_ENABLE) | (byte_w == sfwp_pkg::OP_WR_DISABLE)
		| (byte_w == sfwp_pkg::OP_WR_STATUS) | (byte_w == sfwp_pkg::OP_ERASE_4K)
		| (byte_w == sfwp_pkg::OP_ERASE_32K) | (byte_w == sfwp_pkg::OP_ERASE_64K)
		| (byte_w == sfwp_pkg::OP_ERASE_CHIP) | (byte_w == sfwp_pkg::OP_PROGRAM)
		| (byte_w == sfwp_pkg::OP_DEEP_POWER_DOWN) | (byte_w == sfwp_pkg::OP_OTP_ENTER)
		| (byte_w == sfwp_pkg::OP_OTP_EXIT) | (byte_w == sfwp_pkg::OP_WR_SECURITY);

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st_q <= sfwp_pkg::DS_STANDBY;
		end else begin
			unique case (st_q)
				sfwp_pkg::DS_STANDBY: begin
					if (cs_fall)
						st_q <= dpd_q ? sfwp_pkg::DS_IGNORE : sfwp_pkg::DS_ACTIVE;
				end
				sfwp_pkg::DS_ACTIVE: begin
					if (cs_rise)
						st_q <= sfwp_pkg::DS_STANDBY;
					else if (byte_done && nb_q == 10'h0 && (!known_w || (wip_q && !cur_rd)))
						st_q <= sfwp_pkg::DS_IGNORE;
				end
				sfwp_pkg::DS_IGNORE: begin
					if (cs_rise)
						st_q <= sfwp_pkg::DS_STANDBY;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bit_q  <= 3'h0;
			nb_q   <= 10'h0;
			sh_q   <= 8'h0;
			op_q   <= 8'h0;
			srw_q  <= 8'h0;
			addr_q <= 24'h0;
			pg_n_q <= 9'h0;
		end else if (cs_fall) begin
			bit_q  <= 3'h0;
			nb_q   <= 10'h0;
			pg_n_q <= 9'h0;
		end else if (st_q == sfwp_pkg::DS_ACTIVE && sck_rise) begin
			sh_q  <= byte_w;
			bit_q <= bit_q + 3'h1;
			if (byte_done) begin
				if (nb_q != sfwp_pkg::NB_MAX)
					nb_q <= nb_q + 10'h1;
				if (nb_q == 10'h0)
					op_q <= byte_w;
				else if (nb_q <= sfwp_pkg::NB_ADDR_END)
					addr_q <= {addr_q[15:0], byte_w};
				if (nb_q == sfwp_pkg::NB_OPCODE)
					srw_q <= byte_w;
				if (nb_q >= sfwp_pkg::NB_WITH_ADDR && op_q == sfwp_pkg::OP_PROGRAM && pg_n_q != sfwp_pkg::PAGE_BYTES)
					pg_n_q <= pg_n_q + 9'h1;
			end
		end
	end

	// Page buffer holds data until the frame closes cleanly
	always_ff @(posedge core_clk_in) begin
		if (byte_done && nb_q >= sfwp_pkg::NB_WITH_ADDR && op_q == sfwp_pkg::OP_PROGRAM
			&& pg_n_q != sfwp_pkg::PAGE_BYTES)
			page_mem[pg_n_q[7:0]] <= byte_w;
	end

	// ----------------------------------------
	// Protection decode
	// ----------------------------------------
	function automatic logic blk_prot(input logic [3:0] lvl, input logic tbs, input logic [3:0] blk);
		logic [4:0] n;
		n = (lvl == 4'h0) ? 5'h0 : (lvl >= sfwp_pkg::LVL_ALL) ? sfwp_pkg::BLOCKS : 5'(5'h1 << (lvl - 4'h1));
		blk_prot = tbs ? ({1'b0, blk} < n) : ({1'b0, blk} >= sfwp_pkg::BLOCKS - n);
	endfunction

	wire [7:0] stat_w = {swl_q, tbs_q, lvl_q, wel_q, wip_q};
	wire [7:0] sec_w  = {6'h0, cust_q, fac_q};
	wire hw_lock  = swl_q & ~wp_n_s & ~quad_mode_in;
	wire prot_w   = blk_prot(lvl_q, tbs_q, addr_q[sfwp_pkg::BLK_LSB +: 4]);
	wire otp_lk   = addr_q[sfwp_pkg::OTP_HALF_BIT] ? fac_q : cust_q;
	wire exec     = (st_q == sfwp_pkg::DS_ACTIVE) & cs_rise & (bit_q == 3'h0);
	wire op_er    = (op_q == sfwp_pkg::OP_ERASE_4K) | (op_q == sfwp_pkg::OP_ERASE_32K)
		| (op_q == sfwp_pkg::OP_ERASE_64K);
	wire changer  = op_er | (op_q == sfwp_pkg::OP_ERASE_CHIP) | (op_q == sfwp_pkg::OP_PROGRAM)
		| (op_q == sfwp_pkg::OP_WR_STATUS) | (op_q == sfwp_pkg::OP_WR_SECURITY);
	wire ok_wrsr  = exec & (op_q == sfwp_pkg::OP_WR_STATUS) & (nb_q == sfwp_pkg::NB_STATUS_WR)
		& wel_q & ~hw_lock;
	wire ok_er    = exec & op_er & (nb_q == sfwp_pkg::NB_WITH_ADDR) & wel_q & ~otp_q & ~prot_w;
	wire ok_ce    = exec & (op_q == sfwp_pkg::OP_ERASE_CHIP) & (nb_q == sfwp_pkg::NB_OPCODE) & wel_q
		& ~otp_q & (lvl_q == 4'h0);
	wire ok_pp    = exec & (op_q == sfwp_pkg::OP_PROGRAM) & (nb_q > sfwp_pkg::NB_WITH_ADDR) & wel_q
		& (otp_q ? ~otp_lk : ~prot_w);
	wire ok_scur  = exec & (op_q == sfwp_pkg::OP_WR_SECURITY) & (nb_q == sfwp_pkg::NB_OPCODE) & wel_q;
	wire single   = exec & (nb_q == sfwp_pkg::NB_OPCODE);
	wire [1:0] er_kind_w = (op_q == sfwp_pkg::OP_ERASE_4K) ? sfwp_pkg::ER_4K :
		(op_q == sfwp_pkg::OP_ERASE_32K) ? sfwp_pkg::ER_32K :
		(op_q == sfwp_pkg::OP_ERASE_64K) ? sfwp_pkg::ER_64K : sfwp_pkg::ER_CHIP;
	wire [15:0] ld_cyc = ok_wrsr ? 16'(SRW_CYC) : ok_pp ? 16'(PROG_CYC) : 16'(ERASE_CYC);
	wire ld_busy = ok_wrsr | ok_er | ok_ce | ok_pp | ok_scur;

	// ----------------------------------------
	// Status, locks and busy timing
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wel_q   <= 1'b0;
			lvl_q   <= 4'h0;
			tbs_q   <= 1'b0;
			swl_q   <= 1'b0;
			otp_q   <= 1'b0;
			dpd_q   <= 1'b0;
			cust_q  <= 1'b0;
			fac_q   <= 1'b0;
			strap_q <= 1'b0;
			wcnt_q  <= 16'h0;
			wip_q   <= 1'b0;
		end else begin
			// Strap taken once, after reset release
			if (!strap_q) begin
				fac_q   <= factory_lock_in;
				strap_q <= 1'b1;
			end
			if (single && op_q == sfwp_pkg::OP_WR_ENABLE)
				wel_q <= 1'b1;
			else if (exec && (changer || op_q == sfwp_pkg::OP_WR_DISABLE))
				wel_q <= 1'b0;
			if (ok_wrsr) begin
				lvl_q <= srw_q[sfwp_pkg::SR_LEVEL_LSB +: 4];
				tbs_q <= srw_q[sfwp_pkg::SR_TBSEL_BIT];
				swl_q <= srw_q[sfwp_pkg::SR_LOCK_BIT];
			end
			if (ok_scur)
				cust_q <= 1'b1;
			if (single && op_q == sfwp_pkg::OP_OTP_ENTER)
				otp_q <= 1'b1;
			else if (single && op_q == sfwp_pkg::OP_OTP_EXIT)
				otp_q <= 1'b0;
			if (single && op_q == sfwp_pkg::OP_DEEP_POWER_DOWN)
				dpd_q <= 1'b1;
			else if (st_q == sfwp_pkg::DS_IGNORE && cs_rise && dpd_q)
				dpd_q <= 1'b0;
			wcnt_q <= ld_busy ? ld_cyc : (wcnt_q != 16'h0) ? wcnt_q - 16'h1 : 16'h0;
			wip_q  <= ld_busy | (wcnt_q > 16'h1) | (str_q > 9'h1);
		end
	end

	// ----------------------------------------
	// Array commit outputs
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			er_pulse_out <= 1'b0;
			er_kind_out  <= sfwp_pkg::ER_4K;
			er_addr_out  <= 24'h0;
			str_q        <= 9'h0;
			sidx_q       <= 8'h0;
			pbase_q      <= 24'h0;
			pg_we_out    <= 1'b0;
			pg_otp_out   <= 1'b0;
			pg_addr_out  <= 24'h0;
			pg_data_out  <= 8'h0;
		end else begin
			er_pulse_out <= ok_er | ok_ce;
			if (ok_er | ok_ce) begin
				er_kind_out <= er_kind_w;
				er_addr_out <= addr_q;
			end
			if (ok_pp) begin
				str_q      <= pg_n_q;
				sidx_q     <= 8'h0;
				pbase_q    <= addr_q;
				pg_otp_out <= otp_q;
			end else if (str_q != 9'h0) begin
				str_q  <= str_q - 9'h1;
				sidx_q <= sidx_q + 8'h1;
			end
			pg_we_out <= (str_q != 9'h0) & ~ok_pp;
			if (str_q != 9'h0) begin
				pg_addr_out <= {pbase_q[23:8], pbase_q[7:0] + sidx_q};
				pg_data_out <= page_mem[sidx_q];
			end
		end
	end

	// ----------------------------------------
	// Read-back shifter, driven on falling edges
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			out_q   <= 8'h0;
			so_q    <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			// Reloaded every byte so polling sees fresh busy state
			if (byte_done && cur_rd)
				out_q <= (cur_op == sfwp_pkg::OP_RD_STATUS) ? stat_w : sec_w;
			else if (sck_fall && rd_q) begin
				so_q  <= out_q[7];
				out_q <= {out_q[6:0], 1'b0};
			end
			so_oe_q <= (st_q == sfwp_pkg::DS_ACTIVE) & rd_q & (nb_q != 10'h0) & ~cs_n_s;
		end
	end

	assign link.so                = so_q;
	assign link.so_oe             = so_oe_q;
	assign write_in_progress_out  = wip_q;
	assign write_enable_latch_out = wel_q;
	assign dpd_out                = dpd_q;
	assign otp_mode_out           = otp_q;
endmodule
`default_nettype wire

// ==== logic/sfwp_host.sv ====
// Host controller: Avalon-MM registers driving the serial frame engine
`timescale 1ns/1ps
`default_nettype none
module sfwp_host #(
	parameter int unsigned HALF_CYC = 8
) (
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	sfwp_if.host             link,
	input  wire logic [1:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic [31:0]      avs_readdata_out,
	output logic             avs_waitrequest_out
);
	localparam int unsigned OP_BITS  = 8;
	localparam int unsigned HDR_BITS = 32;

	// ----------------------------------------
	// Register port
	// ----------------------------------------
	sfwp_pkg::sfwp_host_st_t st_q;
	logic        wait_q;
	logic [31:0] rdata_q;
	logic [7:0]  op_q;
	logic [7:0]  tx_q;
	logic [7:0]  rx_q;
	logic [23:0] addr_q;
	logic        ad_q;
	logic        wp_q;
	logic [2:0]  nd_q;
	logic [3:0]  ex_q;
	logic [7:0]  cnt_q;
	logic [7:0]  idx_q;
	logic        cs_n_q;
	logic        sclk_q;
	logic        si_q;
	logic [1:0]  so_sync_q;

	wire busy   = (st_q != sfwp_pkg::HS_IDLE);
	wire req    = avs_read_in | avs_write_in;
	wire cmd_wr = avs_write_in & (avs_address_in == sfwp_pkg::REG_CMD);
	// A new command stalls until the engine is back in idle, after the gap that follows the frame
	wire grant  = req & wait_q & ~(cmd_wr & busy);
	wire take   = req & ~wait_q;
	wire start  = take & cmd_wr;
	wire [31:0] rd_mux = (avs_address_in == sfwp_pkg::REG_CMD) ? {15'h0000, wp_q, ex_q, nd_q, ad_q, op_q} :
		(avs_address_in == sfwp_pkg::REG_ADDR) ? {8'h00, addr_q} :
		(avs_address_in == sfwp_pkg::REG_TXDATA) ? {24'h000000, tx_q} : {24'h000000, rx_q};

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wait_q    <= 1'b1;
			rdata_q   <= 32'h00000000;
			op_q      <= 8'h00;
			addr_q    <= 24'h000000;
			tx_q      <= 8'h00;
			ad_q      <= 1'b0;
			nd_q      <= 3'h0;
			ex_q      <= 4'h0;
			wp_q      <= 1'b1;
			so_sync_q <= 2'h3;
		end else begin
			wait_q    <= ~grant;
			so_sync_q <= {so_sync_q[0], link.so_line};
			if (grant)
				rdata_q <= rd_mux;
			if (take && avs_write_in && avs_address_in == sfwp_pkg::REG_ADDR)
				addr_q <= avs_writedata_in[23:0];
			if (take && avs_write_in && avs_address_in == sfwp_pkg::REG_TXDATA)
				tx_q <= avs_writedata_in[7:0];
			if (start) begin
				op_q <= avs_writedata_in[sfwp_pkg::CMD_ADDR_BIT - 1:0];
				ad_q <= avs_writedata_in[sfwp_pkg::CMD_ADDR_BIT];
				nd_q <= avs_writedata_in[sfwp_pkg::CMD_NDATA_LSB +: 3];
				ex_q <= avs_writedata_in[sfwp_pkg::CMD_EXTRA_LSB +: 4];
				wp_q <= avs_writedata_in[sfwp_pkg::CMD_WP_BIT];
			end
		end
	end

	// ----------------------------------------
	// Frame engine, mode 0, clock idles low
	// ----------------------------------------
	wire [7:0]  hdr_len  = ad_q ? 8'(HDR_BITS) : 8'(OP_BITS);
	// Extra bits let software send frames that end off a byte boundary
	wire [7:0]  tot_len  = hdr_len + {2'h0, nd_q, 3'h0} + {4'h0, ex_q};
	wire [7:0]  nidx     = idx_q + 8'h01;
	wire        half_end = (cnt_q == 8'(HALF_CYC - 1));
	wire        last_bit = (nidx == tot_len);
	wire [31:0] hdr_w    = {op_q, addr_q};
	wire        nbit     = (nidx < hdr_len) ? hdr_w[~nidx[4:0]] : tx_q[~nidx[2:0]];

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			st_q   <= sfwp_pkg::HS_IDLE;
			cs_n_q <= 1'b1;
			sclk_q <= 1'b0;
			si_q   <= 1'b0;
			cnt_q  <= 8'h00;
			idx_q  <= 8'h00;
			rx_q   <= 8'h00;
		end else begin
			cnt_q <= half_end ? 8'h00 : cnt_q + 8'h01;
			unique case (st_q)
				sfwp_pkg::HS_IDLE: begin
					cnt_q <= 8'h00;
					if (start) begin
						st_q   <= sfwp_pkg::HS_LOW;
						cs_n_q <= 1'b0;
						si_q   <= avs_writedata_in[sfwp_pkg::CMD_ADDR_BIT - 1];
						idx_q  <= 8'h00;
					end
				end
				sfwp_pkg::HS_LOW: begin
					if (half_end) begin
						st_q   <= sfwp_pkg::HS_HIGH;
						sclk_q <= 1'b1;
						rx_q   <= {rx_q[6:0], so_sync_q[1]};
					end
				end
				sfwp_pkg::HS_HIGH: begin
					if (half_end) begin
						sclk_q <= 1'b0;
						idx_q  <= nidx;
						si_q   <= nbit;
						st_q   <= last_bit ? sfwp_pkg::HS_END : sfwp_pkg::HS_LOW;
					end
				end
				sfwp_pkg::HS_END: begin
					if (half_end) begin
						cs_n_q <= 1'b1;
						st_q   <= sfwp_pkg::HS_GAP;
					end
				end
				sfwp_pkg::HS_GAP: begin
					if (half_end)
						st_q <= sfwp_pkg::HS_IDLE;
				end
			endcase
		end
	end

	assign link.cs_n           = cs_n_q;
	assign link.sclk           = sclk_q;
	assign link.si             = si_q;
	assign link.wp_n           = wp_q;
	assign avs_readdata_out    = rdata_q;
	assign avs_waitrequest_out = wait_q;
endmodule
`default_nettype wire

// ==== shared/sfwp_if.sv ====
// Serial link between host controller and flash protection end
`timescale 1ns/1ps
`default_nettype none
interface sfwp_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so;
	logic so_oe;
	logic wp_n;
	logic so_line;
	// Released data line idles high
	assign so_line = so_oe ? so : 1'b1;
	modport device (input cs_n, input sclk, input si, input wp_n, output so, output so_oe);
	modport host (output cs_n, output sclk, output si, output wp_n, input so_line);
endinterface
`default_nettype wire

// ==== shared/sfwp_pkg.sv ====
// Shared constants for the serial flash write-protection link
`default_nettype none
package sfwp_pkg;
	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] OP_WR_ENABLE       = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE      = 8'h04;
	localparam logic [7:0] OP_RD_STATUS       = 8'h05;
	localparam logic [7:0] OP_WR_STATUS       = 8'h01;
	localparam logic [7:0] OP_ERASE_4K        = 8'h20;
	localparam logic [7:0] OP_ERASE_32K       = 8'h52;
	localparam logic [7:0] OP_ERASE_64K       = 8'hd8;
	localparam logic [7:0] OP_ERASE_CHIP      = 8'h60;
	localparam logic [7:0] OP_PROGRAM         = 8'h02;
	localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hb9;
	localparam logic [7:0] OP_OTP_ENTER       = 8'hb1;
	localparam logic [7:0] OP_OTP_EXIT        = 8'hc1;
	localparam logic [7:0] OP_RD_SECURITY     = 8'h2b;
	localparam logic [7:0] OP_WR_SECURITY     = 8'h2f;
	// ----------------------------------------
	// Status and security layout
	// ----------------------------------------
	localparam int SR_BUSY_BIT      = 0;
	localparam int SR_LATCH_BIT     = 1;
	localparam int SR_LEVEL_LSB     = 2;
	localparam int SR_TBSEL_BIT     = 6;
	localparam int SR_LOCK_BIT      = 7;
	localparam int SEC_FACTORY_BIT  = 0;
	localparam int SEC_CUSTOMER_BIT = 1;
	// ----------------------------------------
	// Geometry and frame lengths
	// ----------------------------------------
	localparam int             BLK_LSB      = 16;
	localparam int             OTP_HALF_BIT = 9;
	localparam logic [4:0]     BLOCKS       = 5'h10;
	localparam logic [3:0]     LVL_ALL      = 4'h5;
	localparam logic [8:0]     PAGE_BYTES   = 9'h100;
	localparam logic [9:0]     NB_OPCODE    = 10'h001;
	localparam logic [9:0]     NB_STATUS_WR = 10'h002;
	localparam logic [9:0]     NB_ADDR_END  = 10'h003;
	localparam logic [9:0]     NB_WITH_ADDR = 10'h004;
	localparam logic [9:0]     NB_MAX       = 10'h3ff;
	localparam logic [1:0]     ER_4K        = 2'h0;
	localparam logic [1:0]     ER_32K       = 2'h1;
	localparam logic [1:0]     ER_64K       = 2'h2;
	localparam logic [1:0]     ER_CHIP      = 2'h3;
	// ----------------------------------------
	// Host controller registers (word index)
	// ----------------------------------------
	localparam logic [1:0] REG_CMD     = 2'h0;
	localparam logic [1:0] REG_ADDR    = 2'h1;
	localparam logic [1:0] REG_TXDATA  = 2'h2;
	localparam logic [1:0] REG_RXDATA  = 2'h3;
	localparam int         CMD_ADDR_BIT   = 8;
	localparam int         CMD_NDATA_LSB  = 9;
	localparam int         CMD_EXTRA_LSB  = 12;
	localparam int         CMD_WP_BIT     = 16;
	// ----------------------------------------
	// State machines
	// ----------------------------------------
	typedef enum logic [2:0] {
		DS_STANDBY = 3'b001,
		DS_ACTIVE  = 3'b010,
		DS_IGNORE  = 3'b100
	} sfwp_dev_st_t;
	typedef enum logic [4:0] {
		HS_IDLE = 5'b00001,
		HS_LOW  = 5'b00010,
		HS_HIGH = 5'b00100,
		HS_END  = 5'b01000,
		HS_GAP  = 5'b10000
	} sfwp_host_st_t;
endpackage
`default_nettype wire

// ==== tb/sfwp_bench.sv ====
// Bench joining host controller and flash end over the serial link
`timescale 1ns/1ps
`default_nettype none
module sfwp_bench;
	logic        core_clk_in;
	logic        rst_in;
	logic [1:0]  avs_address_in;
	logic        avs_read_in;
	logic        avs_write_in;
	logic [31:0] avs_writedata_in;
	logic [31:0] avs_readdata_out;
	logic        avs_waitrequest_out;
	logic        quad_mode_in;
	logic        factory_lock_in;
	logic        write_in_progress, write_enable_latch, dpd, otp, er_p, pg_we, pg_otp, wp_q;
	logic [1:0]  er_kind;
	logic [23:0] er_addr;
	logic [23:0] pg_addr;
	logic [7:0]  pg_data;
	int          num_errors, n_compared, n_pg, n_er;
	sfwp_if lnk();
	sfwp_host #(.HALF_CYC(8)) i_sfwp_host (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(lnk),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out));
	// Long busy times so a status read can still see the operation running
	sfwp_device #(.PROG_CYC(600), .ERASE_CYC(900), .SRW_CYC(300)) i_sfwp_device (.core_clk_in(core_clk_in),
		.rst_in(rst_in), .link(lnk), .quad_mode_in(quad_mode_in), .factory_lock_in(factory_lock_in),
		.write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch), .dpd_out(dpd), .otp_mode_out(otp),
		.er_pulse_out(er_p), .er_kind_out(er_kind), .er_addr_out(er_addr), .pg_we_out(pg_we),
		.pg_otp_out(pg_otp), .pg_addr_out(pg_addr), .pg_data_out(pg_data));
	sfwp_monitor i_sfwp_monitor (.core_clk_in(core_clk_in), .rst_in(rst_in), .cs_n(lnk.cs_n),
		.so_oe(lnk.so_oe), .write_in_progress_out(write_in_progress), .write_enable_latch_out(write_enable_latch), .dpd_out(dpd),
		.otp_mode_out(otp), .er_pulse_out(er_p), .pg_we_out(pg_we), .pg_otp_out(pg_otp));
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		if (!rst_in) begin
			n_pg <= n_pg + int'(pg_we);
			n_er <= n_er + int'(er_p);
		end
	end
	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tmo;
		chk("wait_limit", 1, 0);
		test_done();
	endtask
	task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= wr;
		avs_read_in <= !wr;
		@(posedge core_clk_in);
		while (avs_waitrequest_out !== 1'b0 && n < 5000) begin
			@(posedge core_clk_in);
			n++;
		end
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		@(posedge core_clk_in);
		if (n >= 5000) tmo();
	endtask
	task automatic frame(input logic [7:0] op, input logic ad, input logic [23:0] a, input logic [2:0] nd,
		input logic [7:0] tx, input logic [3:0] ex);
		logic [31:0] q;
		int n;
		bus(1'b1, sfwp_pkg::REG_ADDR, {8'h00, a}, q);
		bus(1'b1, sfwp_pkg::REG_TXDATA, {24'h000000, tx}, q);
		bus(1'b1, sfwp_pkg::REG_CMD, {15'h0000, wp_q, ex, nd, ad, op}, q);
		n = 0;
		while (lnk.cs_n !== 1'b0 && n < 300) begin
			@(posedge core_clk_in);
			n++;
		end
		if (n >= 300) tmo();
		while (lnk.cs_n !== 1'b1 && n < 3000) begin
			@(posedge core_clk_in);
			n++;
		end
		if (n >= 3000) tmo();
		repeat (4) @(posedge core_clk_in);
	endtask
	task automatic rd(input logic [7:0] op, output logic [7:0] b);
		logic [31:0] q;
		frame(op, 1'b0, 24'h000000, 3'h1, 8'h00, 4'h0);
		bus(1'b0, sfwp_pkg::REG_RXDATA, 32'h00000000, q);
		b = q[7:0];
	endtask
	task automatic idle;
		logic [7:0] s;
		int n;
		n = 0;
		s = 8'h01;
		while (s[0] !== 1'b0 && n < 40) begin
			rd(sfwp_pkg::OP_RD_STATUS, s);
			n++;
		end
		if (n >= 40) tmo();
	endtask
	task automatic write_enable_command;
		frame(sfwp_pkg::OP_WR_ENABLE, 1'b0, 24'h000000, 3'h0, 8'h00, 4'h0);
	endtask
	task automatic set_status(input logic [7:0] b);
		write_enable_command();
		frame(sfwp_pkg::OP_WR_STATUS, 1'b0, 24'h000000, 3'h1, b, 4'h0);
		idle();
	endtask
	task automatic try_prog(input logic [23:0] a, input int ok);
		int n;
		n = n_pg;
		write_enable_command();
		frame(sfwp_pkg::OP_PROGRAM, 1'b1, a, 3'h1, 8'h5a, 4'h0);
		idle();
		chk("prog_count", n_pg - n, ok);
	endtask
	task automatic try_erase(input logic [7:0] op, input logic [23:0] a, input logic [3:0] ex, input int ok);
		int n;
		n = n_er;
		write_enable_command();
		frame(op, op != sfwp_pkg::OP_ERASE_CHIP, a, 3'h0, 8'h00, ex);
		idle();
		chk("erase_count", n_er - n, ok);
	endtask
	task automatic t_basic;
		logic [7:0] s;
		int n;
		rd(sfwp_pkg::OP_RD_STATUS, s);
		chk("status_reset", s, 8'h00);
		n = n_pg;
		frame(sfwp_pkg::OP_PROGRAM, 1'b1, 24'h012345, 3'h1, 8'ha5, 4'h0);
		chk("prog_no_latch", n_pg - n, 0);
		write_enable_command();
		rd(sfwp_pkg::OP_RD_STATUS, s);
		chk("latch_set", s, 8'h02);
		frame(sfwp_pkg::OP_PROGRAM, 1'b1, 24'h012345, 3'h1, 8'ha5, 4'h0);
		rd(sfwp_pkg::OP_RD_STATUS, s);
		chk("busy_seen", s[0], 1'b1);
		idle();
		chk("prog_addr", pg_addr, 24'h012345);
		chk("prog_data", pg_data, 8'ha5);
	endtask
	task automatic t_levels;
		int k;
		for (int t = 0; t < 2; t++) begin
			for (int l = 1; l < 6; l++) begin
				k = (l == 5) ? 16 : (1 << (l - 1));
				set_status({1'b0, t[0], l[3:0], 2'b00});
				try_prog({4'h0, 4'(t ? k - 1 : 16 - k), 16'h0000}, 0);
				if (l < 5) try_prog({4'h0, 4'(t ? k : 15 - k), 16'h0000}, 1);
			end
		end
		try_erase(sfwp_pkg::OP_ERASE_CHIP, 24'h000000, 4'h0, 0);
		set_status(8'h00);
		try_erase(sfwp_pkg::OP_ERASE_CHIP, 24'h000000, 4'h0, 1);
		chk("erase_kind", er_kind, sfwp_pkg::ER_CHIP);
		try_erase(sfwp_pkg::OP_ERASE_4K, 24'h031000, 4'h3, 0);
		try_erase(sfwp_pkg::OP_ERASE_4K, 24'h031000, 4'h0, 1);
		chk("erase_kind", er_kind, sfwp_pkg::ER_4K);
		try_erase(sfwp_pkg::OP_ERASE_32K, 24'h038000, 4'h0, 1);
		chk("erase_kind", er_kind, sfwp_pkg::ER_32K);
		try_erase(sfwp_pkg::OP_ERASE_64K, 24'h040000, 4'h0, 1);
		chk("erase_kind", er_kind, sfwp_pkg::ER_64K);
	endtask
	task automatic t_guard;
		logic [7:0] s;
		set_status(8'h80);
		wp_q = 1'b0;
		set_status(8'h84);
		rd(sfwp_pkg::OP_RD_STATUS, s);
		chk("status_hw_locked", s, 8'h80);
		quad_mode_in <= 1'b1;
		set_status(8'h84);
		rd(sfwp_pkg::OP_RD_STATUS, s);
		chk("status_quad", s, 8'h84);
		set_status(8'h00);
		quad_mode_in <= 1'b0;
		wp_q = 1'b1;
		rd(sfwp_pkg::OP_RD_SECURITY, s);
		chk("security_reset", s, 8'h01);
		frame(sfwp_pkg::OP_OTP_ENTER, 1'b0, 24'h000000, 3'h0, 8'h00, 4'h0);
		chk("otp_mode", otp, 1'b1);
		try_prog(24'h000210, 0);
		try_prog(24'h000010, 1);
		chk("otp_target", pg_otp, 1'b1);
		try_erase(sfwp_pkg::OP_ERASE_4K, 24'h000000, 4'h0, 0);
		write_enable_command();
		frame(sfwp_pkg::OP_WR_SECURITY, 1'b0, 24'h000000, 3'h0, 8'h00, 4'h0);
		idle();
		rd(sfwp_pkg::OP_RD_SECURITY, s);
		chk("security_lock", s, 8'h03);
		try_prog(24'h000010, 0);
		frame(sfwp_pkg::OP_OTP_EXIT, 1'b0, 24'h000000, 3'h0, 8'h00, 4'h0);
		chk("otp_left", otp, 1'b0);
		frame(sfwp_pkg::OP_DEEP_POWER_DOWN, 1'b0, 24'h000000, 3'h0, 8'h00, 4'h0);
		chk("power_down", dpd, 1'b1);
		write_enable_command();
		chk("latch_in_power_down", write_enable_latch, 1'b0);
	endtask
	initial begin
		{n_pg, n_er, num_errors, n_compared} = '0;
		{avs_address_in, avs_read_in, avs_write_in, avs_writedata_in} = '0;
		{quad_mode_in, wp_q} = 2'b01;
		factory_lock_in = 1'b1;
		rst_in = 1'b1;
		repeat (16) @(posedge core_clk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		t_basic();
		t_levels();
		t_guard();
		test_done();
	end
endmodule
`default_nettype wire

// ==== tb/sfwp_monitor.sv ====
// Concurrent checks on the serial link and the flash end outputs
`timescale 1ns/1ps
`default_nettype none
module sfwp_monitor (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic cs_n,
	input wire logic so_oe,
	input wire logic write_in_progress_out,
	input wire logic write_enable_latch_out,
	input wire logic dpd_out,
	input wire logic otp_mode_out,
	input wire logic er_pulse_out,
	input wire logic pg_we_out,
	input wire logic pg_otp_out
);
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	a_so_released: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3) |-> !so_oe)
		else $error("so driven while idle");
	a_erase_after_frame: assert property (er_pulse_out |-> cs_n) else $error("erase inside frame");
	a_prog_after_frame: assert property (pg_we_out |-> cs_n) else $error("program inside frame");
	a_busy_needs_latch: assert property ($rose(write_in_progress_out) |->
		$past(write_enable_latch_out) || $past(write_enable_latch_out, 2)) else $error("busy without latch");
	a_dpd_silent: assert property (dpd_out |-> !pg_we_out && !er_pulse_out && !so_oe)
		else $error("activity in power down");
	a_otp_no_erase: assert property (otp_mode_out |-> !er_pulse_out) else $error("erase in otp mode");
	a_otp_prog_kind: assert property (pg_we_out |-> pg_otp_out == otp_mode_out)
		else $error("program target mismatch");
	a_erase_busy: assert property (er_pulse_out |-> ##[0:2] write_in_progress_out)
		else $error("erase without busy");
endmodule
`default_nettype wire
